// >>> rtl/bchp_bridge_hdr.sv
// Bridge configuration header slice: upper window registers, capability pointer,
// interrupt line/pin, bridge control and power management capability.
// Assumes configuration requests arrive synchronous to CLK, one per cycle at most,
// and that strap defaults are loaded by an external loader while LOAD_STRAP is high.
`timescale 1ns/1ps
`include "bchp_cfg.svh"

// Summary of operation
// - Prefetchable limit upper 32 bits, read-write, reset zero.
// - I/O base upper 16 bits in bits 15:0, read-write, reset zero.
// - I/O limit upper 16 bits in bits 31:16, read-write, reset zero.
// - Capability pointer is read-only and returns 40h.
// - Interrupt pin read-only, reset zero, default loadable.
// - Parity response bit 16 enables secondary poisoned TLP detection.
// - Bit 17 gates forwarding of secondary error messages upstream.
// - Bit 18 limits I/O forwarding to top 768 bytes per 1KB in first 64KB.
// - Bit 19 forwards legacy video memory range A0000h to BFFFFh.
// - Video enable forwards I/O 3B0h-3BBh and 3C0h-3DFh; only in first 1KB with 16-bit decoding.
// - Bit 20 selects 10-bit or 16-bit video I/O decoding.
// - Bit 22 triggers hot reset and asserts downstream reset output.
// - Bridge control bits 21, 23-27 read zero; 31:28 reserved.
// - PM capability ID 01h; next pointer 5Ch upstream, 4Ch downstream.
// - PM revision 011b, no device-specific init, D1 and D2 supported.
// - Aux current 111b and PME support 11111b, both loadable.
// - Power state field read-write, reset D0, two-bit encoding.
// - Writing D0 after D3hot causes hot reset without downstream reset, unless no-soft-reset is set.
// - No-soft-reset bit read-only, reset one, loadable default.
// - PME enable bit 8 read-write, reset zero, gates PME message.
// - Data select 12:9 read-write; data scale and status read zero.
// - Prefetchable limit low 20 bits are treated as all ones.
// - I/O limit low 12 bits are treated as all ones.
module bchp_bridge_hdr
  import bchp_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Port role
  input wire logic IS_UPSTREAM,
  // Configuration access
  input wire bchp_cfg_req_type CFG_REQ,
  output logic CFG_RD_VALID,
  output logic [31:0] CFG_RDATA,
  // Loadable defaults
  input wire logic LOAD_STRAP,
  input wire bchp_strap_type STRAP,
  // Lower window fields from the rest of the header
  input wire bchp_win_lo_type WIN_LO,
  // Forwarding decode
  input wire bchp_fwd_req_type FWD_REQ,
  output logic FWD_HIT,
  // Secondary side events
  input wire logic SEC_POISON_IN,
  input wire logic SEC_ERR_MSG_IN,
  output logic SEC_POISON_DET,
  output logic ERR_MSG_FWD,
  // Power management
  input wire logic PME_EVENT,
  output logic PME_MSG,
  output logic [1:0] POWER_STATE,
  // Resets
  output logic HOT_RESET,
  output logic DOWNSTREAM_RESET_OUT
);

  // Software-visible state
  logic [31:0] pf_limit_up;
  logic [15:0] io_base_up;
  logic [15:0] io_limit_up;
  logic [7:0] int_line;
  logic parity_resp;
  logic error_forward_enable;
  logic isa_en;
  logic vga_en;
  logic vga16;
  logic sec_bus_reset;
  bchp_pstate_type pstate;
  logic pme_en;
  logic [3:0] data_sel;
  bchp_strap_type strap;
  logic hot_from_pm;

  // Byte-lane write helpers
  logic [31:0] wmask;
  logic [31:0] next_pf_limit_up;
  logic [31:0] next_dw30;
  logic [31:0] next_dw3c;
  logic [31:0] next_dw44;
  logic wr_2c;
  logic wr_30;
  logic wr_3c;
  logic wr_44;

  // Read images, declared ahead of the lane merges that fold them back in
  logic [31:0] rd_dw3c;
  logic [31:0] rd_dw44;
  logic [31:0] rd_dw40;

  // Expand byte enables into a bit mask
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{CFG_REQ.be[gi]}};
    end
  endgenerate

  assign wr_2c = CFG_REQ.wr && (CFG_REQ.addr == `BCHP_OFF_PF_LIMIT_UP);
  assign wr_30 = CFG_REQ.wr && (CFG_REQ.addr == `BCHP_OFF_IO_UPPER);
  assign wr_3c = CFG_REQ.wr && (CFG_REQ.addr == `BCHP_OFF_INT_BRIDGE);
  assign wr_44 = CFG_REQ.wr && (CFG_REQ.addr == `BCHP_OFF_PM_CSR);

  // Merged values: unenabled lanes keep the old contents
  assign next_pf_limit_up = (CFG_REQ.wdata & wmask) | (pf_limit_up & ~wmask);
  assign next_dw30 = (CFG_REQ.wdata & wmask) | ({io_limit_up, io_base_up} & ~wmask);
  assign next_dw3c = (CFG_REQ.wdata & wmask) | (rd_dw3c & ~wmask);
  assign next_dw44 = (CFG_REQ.wdata & wmask) | (rd_dw44 & ~wmask);

  // Read images of the mixed registers
  always_comb begin
    rd_dw3c = 32'h00000000;
    rd_dw3c[7:0] = int_line;
    rd_dw3c[15:8] = strap.int_pin;
    rd_dw3c[`BCHP_BC_PARITY] = parity_resp;
    rd_dw3c[`BCHP_BC_ERR_FWD] = error_forward_enable;
    rd_dw3c[`BCHP_BC_ISA] = isa_en;
    rd_dw3c[`BCHP_BC_VGA] = vga_en;
    rd_dw3c[`BCHP_BC_VGA16] = vga16;
    rd_dw3c[`BCHP_BC_SEC_RST] = sec_bus_reset; // bits 21, 23-31 stay zero
  end

  always_comb begin
    rd_dw40 = 32'h00000000;
    rd_dw40[7:0] = `BCHP_PM_CAP_ID;
    rd_dw40[15:8] = IS_UPSTREAM ? `BCHP_PM_NEXT_UP : `BCHP_PM_NEXT_DN;
    rd_dw40[18:16] = `BCHP_PM_REVISION;
    rd_dw40[21] = 1'b0; // No device-specific init
    rd_dw40[24:22] = strap.aux_current;
    rd_dw40[25] = 1'b1;
    rd_dw40[26] = 1'b1;
    rd_dw40[31:27] = strap.pme_support;
  end

  always_comb begin
    rd_dw44 = 32'h00000000;
    rd_dw44[1:0] = pstate;
    rd_dw44[3] = strap.no_soft_reset;
    rd_dw44[`BCHP_PM_PME_EN] = pme_en;
    rd_dw44[`BCHP_PM_DSEL_HI:`BCHP_PM_DSEL_LO] = data_sel; // scale and status zero
    // Extension byte 23:16 reads zero
  end

  // Loadable defaults latched on reset and while the loader drives them
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      strap.int_pin <= `BCHP_INT_PIN_RST;
      strap.aux_current <= `BCHP_AUX_CUR_RST;
      strap.pme_support <= `BCHP_PME_SUP_RST;
      strap.no_soft_reset <= `BCHP_NO_SOFT_RST;
    end else if (LOAD_STRAP) begin
      strap <= STRAP;
    end
  end

  // Window upper halves
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      pf_limit_up <= 32'h00000000;
      io_base_up <= 16'h0000;
      io_limit_up <= 16'h0000;
    end else begin
      if (wr_2c) begin
        pf_limit_up <= next_pf_limit_up;
      end
      if (wr_30) begin
        io_base_up <= next_dw30[15:0];
        io_limit_up <= next_dw30[31:16];
      end
    end
  end

  // Interrupt line and bridge control
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      int_line <= 8'h00;
      parity_resp <= 1'b0;
      error_forward_enable <= 1'b0;
      isa_en <= 1'b0;
      vga_en <= 1'b0;
      vga16 <= 1'b0;
      sec_bus_reset <= 1'b0;
    end else if (wr_3c) begin
      int_line <= next_dw3c[7:0];
      parity_resp <= next_dw3c[`BCHP_BC_PARITY];
      error_forward_enable <= next_dw3c[`BCHP_BC_ERR_FWD];
      isa_en <= next_dw3c[`BCHP_BC_ISA];
      vga_en <= next_dw3c[`BCHP_BC_VGA];
      vga16 <= next_dw3c[`BCHP_BC_VGA16];
      sec_bus_reset <= next_dw3c[`BCHP_BC_SEC_RST];
    end
  end

  // Power management control; D3hot to D0 raises an internal hot reset pulse unless no-soft-reset is set
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      pstate <= BCHP_D0;
      pme_en <= 1'b0;
      data_sel <= 4'h0;
      hot_from_pm <= 1'b0;
    end else begin
      hot_from_pm <= 1'b0;
      if (wr_44) begin
        pstate <= bchp_pstate_type'(next_dw44[1:0]);
        pme_en <= next_dw44[`BCHP_PM_PME_EN];
        data_sel <= next_dw44[`BCHP_PM_DSEL_HI:`BCHP_PM_DSEL_LO];
        // No-soft-reset set means the internal reset is skipped
        if (CFG_REQ.be[0] && pstate == BCHP_D3HOT && next_dw44[1:0] == BCHP_D0
            && !strap.no_soft_reset) begin
          hot_from_pm <= 1'b1;
        end
      end
    end
  end

  // Read data from flip-flops, one cycle after the request
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      CFG_RD_VALID <= 1'b0;
      CFG_RDATA <= 32'h00000000;
    end else begin
      CFG_RD_VALID <= CFG_REQ.rd;
      if (CFG_REQ.rd) begin
        case (CFG_REQ.addr)
          `BCHP_OFF_PF_LIMIT_UP: CFG_RDATA <= pf_limit_up;
          `BCHP_OFF_IO_UPPER: CFG_RDATA <= {io_limit_up, io_base_up};
          `BCHP_OFF_CAP_PTR: CFG_RDATA <= {24'h000000, `BCHP_CAP_PTR_VAL};
          `BCHP_OFF_INT_BRIDGE: CFG_RDATA <= rd_dw3c;
          `BCHP_OFF_PM_CAP: CFG_RDATA <= rd_dw40;
          `BCHP_OFF_PM_CSR: CFG_RDATA <= rd_dw44;
          default: CFG_RDATA <= 32'h00000000;
        endcase
      end
    end
  end

  // Assembled window bounds
  logic [63:0] pf_base;
  logic [63:0] pf_limit;
  logic [31:0] io_base;
  logic [31:0] io_limit;
  assign pf_base = {WIN_LO.pf_base_up, WIN_LO.pf_base_lo, 20'h00000};
  assign pf_limit = {pf_limit_up, WIN_LO.pf_limit_lo, `BCHP_PF_LIMIT_LOW};
  assign io_base = {io_base_up, WIN_LO.io_base_lo, 12'h000};
  assign io_limit = {io_limit_up, WIN_LO.io_limit_lo, `BCHP_IO_LIMIT_LOW};

  // Forwarding decode
  logic io_in_win;
  logic io_isa_ok;
  logic io_64k;
  logic vga_io;
  logic vga_mem;
  logic mem_in_win;
  logic next_fwd_hit;
  always_comb begin
    io_64k = (FWD_REQ.addr[31:16] == 16'h0000);
    io_in_win = (FWD_REQ.addr[31:0] >= io_base) && (FWD_REQ.addr[31:0] <= io_limit);
    // Low 256 bytes of each 1KB block in the first 64KB are excluded in ISA mode
    io_isa_ok = !(isa_en && io_64k && FWD_REQ.addr[9:0] < `BCHP_ISA_BLK_LO);
    vga_io = vga_en
      && (vga16 ? io_64k && FWD_REQ.addr[15:10] == 6'h00 : 1'b1)
      && ((FWD_REQ.addr[9:0] >= `BCHP_VGA_IO_A_LO && FWD_REQ.addr[9:0] <= `BCHP_VGA_IO_A_HI)
      || (FWD_REQ.addr[9:0] >= `BCHP_VGA_IO_B_LO
      && FWD_REQ.addr[9:0] <= `BCHP_VGA_IO_B_HI));
    vga_mem = vga_en && FWD_REQ.addr >= `BCHP_VGA_MEM_LO
      && FWD_REQ.addr <= `BCHP_VGA_MEM_HI;
    mem_in_win = (FWD_REQ.addr >= pf_base) && (FWD_REQ.addr <= pf_limit);
    if (FWD_REQ.is_io) begin
      next_fwd_hit = FWD_REQ.valid && ((io_in_win && io_isa_ok) || vga_io);
    end else begin
      next_fwd_hit = FWD_REQ.valid && (mem_in_win || vga_mem);
    end
  end

  // Registered event outputs
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      FWD_HIT <= 1'b0;
      SEC_POISON_DET <= 1'b0;
      ERR_MSG_FWD <= 1'b0;
      PME_MSG <= 1'b0;
      HOT_RESET <= 1'b0;
      DOWNSTREAM_RESET_OUT <= 1'b0;
    end else begin
      FWD_HIT <= next_fwd_hit;
      SEC_POISON_DET <= SEC_POISON_IN && parity_resp;
      ERR_MSG_FWD <= SEC_ERR_MSG_IN && error_forward_enable;
      PME_MSG <= PME_EVENT && pme_en;
      HOT_RESET <= sec_bus_reset || hot_from_pm;
      DOWNSTREAM_RESET_OUT <= sec_bus_reset; // PM-driven reset leaves it low
    end
  end

  assign POWER_STATE = pstate;

endmodule // bchp_bridge_hdr

// >>> rtl/bchp_cfg.svh
// Offsets, field positions, reset values and hard-wired codes of the bridge header slice.
// Assumes registers are addressed by dword-aligned byte offsets within configuration space.
`ifndef BCHP_CFG_SVH
`define BCHP_CFG_SVH

// Register byte offsets
`define BCHP_OFF_PF_LIMIT_UP 8'h2C
`define BCHP_OFF_IO_UPPER 8'h30
`define BCHP_OFF_CAP_PTR 8'h34
`define BCHP_OFF_INT_BRIDGE 8'h3C
`define BCHP_OFF_PM_CAP 8'h40
`define BCHP_OFF_PM_CSR 8'h44

// Hard-wired values
`define BCHP_CAP_PTR_VAL 8'h40
`define BCHP_PM_CAP_ID 8'h01
`define BCHP_PM_NEXT_UP 8'h5C
`define BCHP_PM_NEXT_DN 8'h4C
`define BCHP_PM_REVISION 3'h3

// Loadable defaults
`define BCHP_INT_PIN_RST 8'h00
`define BCHP_AUX_CUR_RST 3'h7
`define BCHP_PME_SUP_RST 5'h1F
`define BCHP_NO_SOFT_RST 1'h1

// Bridge control bit positions within the 0x3C dword
`define BCHP_BC_PARITY 16
`define BCHP_BC_ERR_FWD 17
`define BCHP_BC_ISA 18
`define BCHP_BC_VGA 19
`define BCHP_BC_VGA16 20
`define BCHP_BC_SEC_RST 22

// Power management control/status bit positions within the 0x44 dword
`define BCHP_PM_PME_EN 8
`define BCHP_PM_DSEL_LO 9
`define BCHP_PM_DSEL_HI 12

// Decode constants
`define BCHP_PF_LIMIT_LOW 20'hFFFFF
`define BCHP_IO_LIMIT_LOW 12'hFFF
`define BCHP_VGA_MEM_LO 64'h00000000000A0000
`define BCHP_VGA_MEM_HI 64'h00000000000BFFFF
`define BCHP_VGA_IO_A_LO 10'h3B0
`define BCHP_VGA_IO_A_HI 10'h3BB
`define BCHP_VGA_IO_B_LO 10'h3C0
`define BCHP_VGA_IO_B_HI 10'h3DF
`define BCHP_ISA_BLK_LO 10'h100

`endif

// >>> rtl/bchp_pkg.sv
// Types shared by the bridge header slice and its environment.
// Assumes bchp_cfg.svh carries all numeric constants.
package bchp_pkg;

  // Power states
  typedef enum logic [1:0] {
    BCHP_D0 = 2'b00,
    BCHP_D1 = 2'b01,
    BCHP_D2 = 2'b10,
    BCHP_D3HOT = 2'b11
  } bchp_pstate_type;

  // Configuration request from upstream
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } bchp_cfg_req_type;

  // Lower window fields held elsewhere in the header
  typedef struct packed {
    logic [11:0] pf_base_lo;
    logic [11:0] pf_limit_lo;
    logic [31:0] pf_base_up;
    logic [3:0] io_base_lo;
    logic [3:0] io_limit_lo;
  } bchp_win_lo_type;

  // Loadable read-only defaults
  typedef struct packed {
    logic [7:0] int_pin;
    logic [2:0] aux_current;
    logic [4:0] pme_support;
    logic no_soft_reset;
  } bchp_strap_type;

  // Request to be decoded for forwarding
  typedef struct packed {
    logic valid;
    logic is_io;
    logic [63:0] addr;
  } bchp_fwd_req_type;

endpackage

// >>> verification/bchp_bridge_hdr_monitor.sv
// Checker for the bridge header slice, bound to its top module.
// Assumes only top ports are visible; shadows rebuild the written enables.
`timescale 1ns/1ps
module bchp_bridge_hdr_monitor
  import bchp_pkg::*;
(
  // Clock, reset and configuration access
  input wire logic CLK,
  input wire logic NRST,
  input wire logic IS_UPSTREAM,
  input wire bchp_cfg_req_type CFG_REQ,
  input wire logic CFG_RD_VALID,
  input wire logic [31:0] CFG_RDATA,
  input wire logic LOAD_STRAP,
  input wire bchp_strap_type STRAP,
  // Events, power and resets
  input wire logic SEC_POISON_IN,
  input wire logic SEC_ERR_MSG_IN,
  input wire logic PME_EVENT,
  input wire logic SEC_POISON_DET,
  input wire logic ERR_MSG_FWD,
  input wire logic PME_MSG,
  input wire logic [1:0] POWER_STATE,
  input wire logic HOT_RESET,
  input wire logic DOWNSTREAM_RESET_OUT
);
  logic [6:0] bc;
  logic [1:0] ps;
  logic pme_en;
  logic nsr;
  logic wr_bc;
  logic wr_pm;
  logic wake;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  // Decoded writes; the wake term mirrors the D3hot to D0 case
  assign wr_bc = CFG_REQ.wr && CFG_REQ.addr == 8'h3C && CFG_REQ.be[2];
  assign wr_pm = CFG_REQ.wr && CFG_REQ.addr == 8'h44;
  assign wake = wr_pm && CFG_REQ.be[0] && CFG_REQ.wdata[1:0] == 2'h0 && ps == 2'h3 && !nsr;

  // Shadow of enables, taken at the same edge as the design
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      bc <= 7'h00;
      ps <= 2'h0;
      pme_en <= 1'b0;
    end else begin
      if (wr_bc) bc <= CFG_REQ.wdata[22:16];
      if (wr_pm && CFG_REQ.be[0]) ps <= CFG_REQ.wdata[1:0];
      if (wr_pm && CFG_REQ.be[1]) pme_en <= CFG_REQ.wdata[8];
    end
  end

  // Soft reset skip flag follows the strap loader
  always_ff @(posedge CLK) begin
    if (!NRST) nsr <= 1'b1;
    else if (LOAD_STRAP) nsr <= STRAP.no_soft_reset;
  end

  property p_cap_ptr;
    CFG_REQ.rd && CFG_REQ.addr == 8'h34 |=> CFG_RD_VALID && CFG_RDATA[7:0] == 8'h40;
  endproperty
  a_cap_ptr: assert property (p_cap_ptr)
    else $error("capability pointer read wrong");
  property p_pm_next;
    CFG_REQ.rd && CFG_REQ.addr == 8'h40 |=>
      CFG_RD_VALID && CFG_RDATA[15:0] == {($past(IS_UPSTREAM) ? 8'h5C : 8'h4C), 8'h01};
  endproperty
  a_pm_next: assert property (p_pm_next)
    else $error("power capability header wrong");
  property p_bc_ro;
    CFG_REQ.rd && CFG_REQ.addr == 8'h3C |=> CFG_RDATA[27:23] == 5'h00 && !CFG_RDATA[21];
  endproperty
  a_bc_ro: assert property (p_bc_ro)
    else $error("hard-wired bridge control bit set");
  property p_poison;
    SEC_POISON_DET == $past(SEC_POISON_IN && bc[0]);
  endproperty
  a_poison: assert property (p_poison)
    else $error("poison detect not gated by its enable");
  property p_err_fwd;
    ERR_MSG_FWD == $past(SEC_ERR_MSG_IN && bc[1]);
  endproperty
  a_err_fwd: assert property (p_err_fwd)
    else $error("error message forwarding not gated");
  property p_pme;
    PME_MSG == $past(PME_EVENT && pme_en);
  endproperty
  a_pme: assert property (p_pme)
    else $error("power event message not gated");
  property p_dn_rst;
    DOWNSTREAM_RESET_OUT == $past(bc[6]);
  endproperty
  a_dn_rst: assert property (p_dn_rst)
    else $error("downstream reset does not follow its bit");
  property p_hot;
    HOT_RESET == ($past(bc[6]) || $past(wake, 2));
  endproperty
  a_hot: assert property (p_hot)
    else $error("hot reset cause mismatch");
  property p_pstate;
    wr_pm && CFG_REQ.be[0] |=> POWER_STATE == $past(CFG_REQ.wdata[1:0]);
  endproperty
  a_pstate: assert property (p_pstate)
    else $error("power state not written");
endmodule // bchp_bridge_hdr_monitor

// >>> verification/bchp_host_model.sv
// Upstream configuration requester model for the bridge header slice.
// Assumes calls come from one process, any time after a clock edge.
`timescale 1ns/1ps
module bchp_host_model
  import bchp_pkg::*;
(
  // Clock
  input wire logic clk,
  // Request to the header
  output bchp_cfg_req_type cfg_req
);
  initial cfg_req = '0;

  // One request per call, held across the taking edge
  task automatic xfer(input logic r, input logic w, input logic [7:0] a, input logic [3:0] b,
      input logic [31:0] d);
    @(posedge clk);
    #1;
    cfg_req = {r, w, a, b, d};
    @(posedge clk);
    #1;
    // Idle lanes flip so stale data never looks live
    cfg_req = {2'b00, ~cfg_req[43:0]};
  endtask
endmodule // bchp_host_model

// >>> verification/tb.sv
// Self-checking bench for the bridge header slice, its requester model and checker.
// Assumes design, package, checker and model are compiled before this file.
`timescale 1ns/1ps
module tb;
  import bchp_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic is_up = 1'b1;
  bchp_cfg_req_type cfg_req;
  logic rd_valid;
  logic [31:0] rdata;
  logic load_strap = 1'b0;
  bchp_strap_type strap = '0;
  bchp_win_lo_type win_lo = {12'h000, 12'h000, 32'h00000001, 4'h1, 4'h1};
  bchp_fwd_req_type fwd_req = '0;
  logic fwd_hit, poison_det, err_fwd, pme_msg, hot_rst, dn_rst;
  logic poison_in = 1'b0;
  logic err_in = 1'b0;
  logic pme_ev = 1'b0;
  logic [1:0] pstate;
  int n_mismatch = 0;
  int check_count = 0;
  int seed = 32'hCAC6;
  logic [31:0] rq [$];
  logic fq [$];
  logic fwd_seen = 1'b0;
  logic [7:0] ra [6] = '{8'h2C, 8'h30, 8'h34, 8'h3C, 8'h40, 8'h44};
  logic [31:0] rm [6] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, 32'h005F00FF, 32'h0, 32'h1F03};
  logic [31:0] rf [6] = '{32'h0, 32'h0, 32'h40, 32'h0, 32'hFFC35C01, 32'h8};
  logic [31:0] dl [6];
  // Decode cases: {16-bit video, video, isa}, io, address, expected hit
  logic [68:0] fc [15] = '{{3'h0, 1'h0, 64'h1000FFFFF, 1'h1}, {3'h0, 1'h0, 64'h100100000, 1'h0},
    {3'h0, 1'h0, 64'hFFFFFFFF, 1'h0}, {3'h0, 1'h1, 64'h1FFF, 1'h1}, {3'h0, 1'h1, 64'h2000, 1'h0},
    {3'h0, 1'h0, 64'hA0000, 1'h0}, {3'h2, 1'h0, 64'hA0000, 1'h1}, {3'h2, 1'h0, 64'hBFFFF, 1'h1},
    {3'h2, 1'h0, 64'hC0000, 1'h0}, {3'h2, 1'h1, 64'h23C0, 1'h1}, {3'h2, 1'h1, 64'h3BC, 1'h0},
    {3'h6, 1'h1, 64'h23C0, 1'h0}, {3'h6, 1'h1, 64'h3DF, 1'h1}, {3'h1, 1'h1, 64'h1000, 1'h0},
    {3'h1, 1'h1, 64'h1100, 1'h1}};

  bchp_bridge_hdr u_bchp_bridge_hdr (
    .CLK(clk), .NRST(nrst), .IS_UPSTREAM(is_up), .CFG_REQ(cfg_req), .CFG_RD_VALID(rd_valid),
    .CFG_RDATA(rdata), .LOAD_STRAP(load_strap), .STRAP(strap), .WIN_LO(win_lo),
    .FWD_REQ(fwd_req), .FWD_HIT(fwd_hit), .SEC_POISON_IN(poison_in), .SEC_ERR_MSG_IN(err_in),
    .SEC_POISON_DET(poison_det), .ERR_MSG_FWD(err_fwd), .PME_EVENT(pme_ev), .PME_MSG(pme_msg),
    .POWER_STATE(pstate), .HOT_RESET(hot_rst), .DOWNSTREAM_RESET_OUT(dn_rst));
  bchp_host_model u_bchp_host_model (.clk(clk), .cfg_req(cfg_req));

  always #2.5 clk = ~clk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rq.push_back(exp);
    u_bchp_host_model.xfer(1'b1, 1'b0, a, 4'hF, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    u_bchp_host_model.xfer(1'b0, 1'b1, a, b, d);
  endtask

  // Sets the decode controls, then offers one address for one cycle
  task automatic fwd(input logic [68:0] c);
    wr(8'h3C, 4'h4, {11'h000, c[68:66], 18'h00000});
    @(posedge clk);
    #1;
    fwd_req = {1'b1, c[65], c[64:1]};
    fq.push_back(c[0]);
    @(posedge clk);
    #1;
    fwd_req.valid = 1'b0;
  endtask

  // Secondary events toggle at random so the gating is seen both ways
  always @(posedge clk) begin
    #1;
    {poison_in, err_in, pme_ev} = 3'($random(seed));
  end

  // Answers are compared at mid-cycle, when settled
  always @(posedge clk) fwd_seen <= fwd_req.valid;
  always @(negedge clk) begin
    if (rd_valid === 1'b1) check("read data", rdata, rq.pop_front());
    if (fwd_seen) check("forward hit", {31'h0, fwd_hit}, {31'h0, fq.pop_front()});
  end

  initial begin
    repeat (4) @(posedge clk);
    #1;
    nrst = 1'b1;
    foreach (ra[i]) rd(ra[i], rf[i]);
    rd(8'h38, 32'h0);
    // Random writes over all lanes, both port roles
    for (int k = 0; k < 4; k++) begin
      is_up = k[0];
      rf[4][15:8] = k[0] ? 8'h5C : 8'h4C;
      foreach (ra[i]) begin
        dl[i] = $random(seed);
        wr(ra[i], 4'hF, dl[i]);
        rd(ra[i], (dl[i] & rm[i]) | rf[i]);
      end
    end
    is_up = 1'b0;
    strap = {8'h01, 3'h2, 5'h0A, 1'b0};
    load_strap = 1'b1;
    @(posedge clk);
    #1;
    load_strap = 1'b0;
    rd(8'h3C, (dl[3] & rm[3]) | 32'h00000100);
    rd(8'h40, 32'h56834C01);
    rd(8'h44, dl[5] & rm[5]);
    wr(8'h2C, 4'hF, 32'h00000001);
    wr(8'h30, 4'hF, 32'h00000000);
    foreach (fc[i]) fwd(fc[i]);
    // Wake from D3hot with internal reset allowed
    wr(8'h44, 4'h1, 32'h00000003);
    wr(8'h44, 4'h1, 32'h00000000);
    repeat (3) @(posedge clk);
    stop_test();
  end

  // Whole run is under two hundred cycles; this cuts a hang short
  initial begin
    #100000;
    n_mismatch++;
    stop_test();
  end
endmodule // tb

bind bchp_bridge_hdr bchp_bridge_hdr_monitor u_bchp_bridge_hdr_monitor (.CLK, .NRST,
  .IS_UPSTREAM, .CFG_REQ, .CFG_RD_VALID, .CFG_RDATA, .LOAD_STRAP, .STRAP, .SEC_POISON_IN,
  .SEC_ERR_MSG_IN, .PME_EVENT, .SEC_POISON_DET, .ERR_MSG_FWD, .PME_MSG, .POWER_STATE,
  .HOT_RESET, .DOWNSTREAM_RESET_OUT);
